// [include/ifs_defs.vh]
// constants for the instruction fetch and operation sampler
`ifndef IFS_DEFS_VH
`define IFS_DEFS_VH
// ==========================================
// register byte offsets
`define IFS_FETCH_CTL 6'h00
`define IFS_FETCH_CNT 6'h04
`define IFS_FETCH_VADDR 6'h08
`define IFS_FETCH_PADDR 6'h0c
`define IFS_FETCH_INFO 6'h10
`define IFS_OP_CTL 6'h14
`define IFS_OP_CNT 6'h18
`define IFS_OP_PARENT 6'h1c
`define IFS_OP_DATA 6'h20
// ==========================================
// control register fields
`define IFS_CTL_MAX_HI 15
`define IFS_CTL_MAX_LO 0
`define IFS_CTL_EN 16
`define IFS_CTL_RAND 17
`define IFS_CTL_VALID 18
// ==========================================
// fetch info register fields
`define IFS_INFO_LAT_HI 15
`define IFS_INFO_LAT_LO 0
`define IFS_INFO_COMP 16
`define IFS_INFO_ICMISS 17
`define IFS_INFO_L1MISS 18
`define IFS_INFO_L2MISS 19
`define IFS_INFO_PGSZ_LO 20
`define IFS_INFO_PGSZ_HI 21
`define IFS_INFO_PVALID 22
// ==========================================
// operation data register fields
`define IFS_OPD_RETCYC_HI 15
`define IFS_OPD_RETCYC_LO 0
`define IFS_OPD_KIND_HI 31
`define IFS_OPD_KIND_LO 16
// ==========================================
// widths, reset values, lfsr
`define IFS_CNT_W 20
`define IFS_LAT_W 16
`define IFS_LAT_MAX 16'hffff
`define IFS_CNT_RST 20'h00000
`define IFS_MAX_RST 16'h0000
`define IFS_LFSR_SEED 7'h01
`endif

// [verilog/ifs_sampler.v]
// instruction fetch and operation sampler with avalon-mm register slave
// ==========================================
// Contract
// - fetch and op sampling are independent, separately enabled, may run together
// - fetch counter advances once per completed fetch, never on aborts
// - op counter advances once every clock cycle
// - fetch counter equal to maximum tags the next attempted fetch
// - events caused by the tagged fetch or op are captured into results
// - interrupt on tagged fetch completion or abort, data reported both ways
// - counter and maximum are 20 bits; software writes all 20 counter bits and the upper 16 of the maximum
// - low four bits of the maximum always read as zero
// - fetch counter resets when it reaches the maximum
// - randomize loads counter low four bits from a 7-bit maximal lfsr
// - virtual fetch address always reported for every fetch sample
// - physical valid flag only when physical address and page size valid
// - first and second level itlb miss flags on initial misses
// - icache miss flag on initial instruction cache miss
// - complete flag only when bytes reached decoders, else aborted
// - latency counts cycles from fetch start to delivery or abort
// - two-bit page size used by first level itlb reported
// - op sample records the parent instruction address
// - op sample reports retirement cycles and op-kind execution data
// - miss flags reflect only the first access attempt
// - op interrupt only when the tagged op retires
// - flushed tagged op drops sample, counter loads random 7-bit value
`include "ifs_defs.vh"
`default_nettype none

module ifs_sampler (
	input wire clk,
	input wire rst,
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire fetch_complete,
	output reg fetch_tag_req,
	input wire fetch_tag_start,
	input wire [31:0] fetch_vaddr,
	input wire tag_xlat_done,
	input wire tag_xlat_ok,
	input wire tag_l1_miss,
	input wire tag_l2_miss,
	input wire [31:0] tag_paddr,
	input wire [1:0] tag_page_size,
	input wire tag_ic_access,
	input wire tag_ic_miss,
	input wire tag_done,
	input wire tag_abort,
	output reg fetch_sample_irq,
	output reg op_tag_req,
	input wire op_tagged,
	input wire op_retire,
	input wire op_flush,
	input wire [31:0] op_parent_addr,
	input wire [15:0] op_kind_data,
	output reg op_sample_irq
);

	localparam [1:0] S_COUNT = 2'h0;
	localparam [1:0] S_ARM = 2'h1;
	localparam [1:0] S_TRACK = 2'h2;

	// ==========================================
	// helpers
	function [31:0] merge_be;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		integer i;
		begin
			merge_be = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					merge_be[i*8 +: 8] = wd[i*8 +: 8];
				end
			end
		end
	endfunction

	function [`IFS_LAT_W-1:0] sat_inc;
		input [`IFS_LAT_W-1:0] v;
		begin
			sat_inc = (v == `IFS_LAT_MAX) ? v : v + 16'h0001;
		end
	endfunction

	// ==========================================
	// state
	reg [6:0] lfsr;
	reg [1:0] fstate;
	reg f_en;
	reg f_rand;
	reg f_valid;
	reg [15:0] f_max_hi;
	reg [`IFS_CNT_W-1:0] f_count;
	reg [31:0] f_vaddr;
	reg [31:0] f_paddr;
	reg [1:0] f_pgsz;
	reg [`IFS_LAT_W-1:0] f_lat;
	reg f_comp;
	reg f_icmiss;
	reg f_l1miss;
	reg f_l2miss;
	reg f_pvalid;
	reg f_xlat_seen;
	reg f_ic_seen;

	reg [1:0] ostate;
	reg o_en;
	reg o_valid;
	reg [15:0] o_max_hi;
	reg [`IFS_CNT_W-1:0] o_count;
	reg [31:0] o_parent;
	reg [`IFS_LAT_W-1:0] o_retcyc;
	reg [15:0] o_kind;

	wire bus_wr = avs_write && !avs_waitrequest;
	// low nibble forced to zero so the period is a multiple of 16
	wire [`IFS_CNT_W-1:0] f_max = {f_max_hi, 4'h0};
	wire [`IFS_CNT_W-1:0] o_max = {o_max_hi, 4'h0};
	wire [31:0] ctl_wd_f = merge_be({13'h0000, f_valid, f_rand, f_en, f_max_hi},
		avs_writedata, avs_byteenable);
	wire [31:0] ctl_wd_o = merge_be({13'h0000, o_valid, 1'b0, o_en, o_max_hi},
		avs_writedata, avs_byteenable);
	wire [31:0] cnt_wd_f = merge_be({12'h000, f_count}, avs_writedata, avs_byteenable);
	wire [31:0] cnt_wd_o = merge_be({12'h000, o_count}, avs_writedata, avs_byteenable);

	// ==========================================
	// lfsr, x^7 + x^6 + 1, free running
	always @(posedge clk) begin
		if (rst) begin
			lfsr <= `IFS_LFSR_SEED;
		end else begin
			lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
		end
	end

	// ==========================================
	// fetch sampling
	always @(posedge clk) begin
		if (rst) begin
			fstate <= S_COUNT;
			fetch_tag_req <= 1'b0;
			fetch_sample_irq <= 1'b0;
			f_en <= 1'b0;
			f_rand <= 1'b0;
			f_valid <= 1'b0;
			f_max_hi <= `IFS_MAX_RST;
			f_count <= `IFS_CNT_RST;
			f_vaddr <= 32'h00000000;
			f_paddr <= 32'h00000000;
			f_pgsz <= 2'h0;
			f_lat <= 16'h0000;
			f_comp <= 1'b0;
			f_icmiss <= 1'b0;
			f_l1miss <= 1'b0;
			f_l2miss <= 1'b0;
			f_pvalid <= 1'b0;
			f_xlat_seen <= 1'b0;
			f_ic_seen <= 1'b0;
		end else begin
			if (bus_wr && avs_address == `IFS_FETCH_CTL) begin
				f_max_hi <= ctl_wd_f[`IFS_CTL_MAX_HI:`IFS_CTL_MAX_LO];
				f_en <= ctl_wd_f[`IFS_CTL_EN];
				f_rand <= ctl_wd_f[`IFS_CTL_RAND];
				// zero clears the sample flag; a fresh sample below wins
				if (!ctl_wd_f[`IFS_CTL_VALID]) begin
					f_valid <= 1'b0;
				end
			end
			if (bus_wr && avs_address == `IFS_FETCH_CNT) begin
				f_count <= cnt_wd_f[`IFS_CNT_W-1:0];
			end
			case (fstate)
			S_COUNT: begin
				// a pending sample or a clear enable freezes the counter
				if (f_en && !f_valid) begin
					if (f_count == f_max) begin
						f_count <= f_rand ? {16'h0000, lfsr[3:0]} : `IFS_CNT_RST;
						fstate <= S_ARM;
						fetch_tag_req <= 1'b1;
					end else if (fetch_complete) begin
						f_count <= f_count + 20'h00001;
					end
				end
			end
			S_ARM: begin
				if (!f_en) begin
					fstate <= S_COUNT;
					fetch_tag_req <= 1'b0;
				end else if (fetch_tag_start) begin
					fstate <= S_TRACK;
					fetch_tag_req <= 1'b0;
					f_vaddr <= fetch_vaddr;
					f_lat <= 16'h0000;
					f_paddr <= 32'h00000000;
					f_pgsz <= 2'h0;
					f_comp <= 1'b0;
					f_icmiss <= 1'b0;
					f_l1miss <= 1'b0;
					f_l2miss <= 1'b0;
					f_pvalid <= 1'b0;
					f_xlat_seen <= 1'b0;
					f_ic_seen <= 1'b0;
				end
			end
			S_TRACK: begin
				f_lat <= sat_inc(f_lat);
				// only the first attempt is recorded, retries are ignored
				if (tag_xlat_done && !f_xlat_seen) begin
					f_xlat_seen <= 1'b1;
					f_l1miss <= tag_l1_miss;
					f_l2miss <= tag_l2_miss;
				end
				if (tag_xlat_done && tag_xlat_ok && !f_pvalid) begin
					f_pvalid <= 1'b1;
					f_paddr <= tag_paddr;
					f_pgsz <= tag_page_size;
				end
				if (tag_ic_access && !f_ic_seen) begin
					f_ic_seen <= 1'b1;
					f_icmiss <= tag_ic_miss;
				end
				if (tag_done || tag_abort) begin
					f_comp <= tag_done && !tag_abort;
					f_valid <= 1'b1;
					fstate <= S_COUNT;
				end
			end
			default: begin
				fstate <= S_COUNT;
				fetch_tag_req <= 1'b0;
			end
			endcase
			fetch_sample_irq <= f_valid && f_en;
		end
	end

	// ==========================================
	// op sampling
	always @(posedge clk) begin
		if (rst) begin
			ostate <= S_COUNT;
			op_tag_req <= 1'b0;
			op_sample_irq <= 1'b0;
			o_en <= 1'b0;
			o_valid <= 1'b0;
			o_max_hi <= `IFS_MAX_RST;
			o_count <= `IFS_CNT_RST;
			o_parent <= 32'h00000000;
			o_retcyc <= 16'h0000;
			o_kind <= 16'h0000;
		end else begin
			if (bus_wr && avs_address == `IFS_OP_CTL) begin
				o_max_hi <= ctl_wd_o[`IFS_CTL_MAX_HI:`IFS_CTL_MAX_LO];
				o_en <= ctl_wd_o[`IFS_CTL_EN];
				if (!ctl_wd_o[`IFS_CTL_VALID]) begin
					o_valid <= 1'b0;
				end
			end
			if (bus_wr && avs_address == `IFS_OP_CNT) begin
				o_count <= cnt_wd_o[`IFS_CNT_W-1:0];
			end
			case (ostate)
			S_COUNT: begin
				if (o_en && !o_valid) begin
					if (o_count == o_max) begin
						o_count <= `IFS_CNT_RST;
						ostate <= S_ARM;
						op_tag_req <= 1'b1;
					end else begin
						o_count <= o_count + 20'h00001;
					end
				end
			end
			S_ARM: begin
				if (!o_en) begin
					ostate <= S_COUNT;
					op_tag_req <= 1'b0;
				end else if (op_tagged) begin
					ostate <= S_TRACK;
					op_tag_req <= 1'b0;
					o_retcyc <= 16'h0000;
				end
			end
			S_TRACK: begin
				o_retcyc <= sat_inc(o_retcyc);
				if (op_flush) begin
					// dropped sample; restart from a random point
					o_count <= {13'h0000, lfsr};
					ostate <= S_COUNT;
				end else if (op_retire) begin
					o_parent <= op_parent_addr;
					o_kind <= op_kind_data;
					o_valid <= 1'b1;
					ostate <= S_COUNT;
				end
			end
			default: begin
				ostate <= S_COUNT;
				op_tag_req <= 1'b0;
			end
			endcase
			op_sample_irq <= o_valid && o_en;
		end
	end

	// ==========================================
	// avalon-mm slave, one wait state per access
	reg [31:0] next_readdata;

	always @* begin
		case (avs_address)
		`IFS_FETCH_CTL: next_readdata = {13'h0000, f_valid, f_rand, f_en, f_max_hi};
		`IFS_FETCH_CNT: next_readdata = {12'h000, f_count};
		`IFS_FETCH_VADDR: next_readdata = f_vaddr;
		`IFS_FETCH_PADDR: next_readdata = f_paddr;
		`IFS_FETCH_INFO: next_readdata = {9'h000, f_pvalid, f_pgsz, f_l2miss, f_l1miss,
			f_icmiss, f_comp, f_lat};
		`IFS_OP_CTL: next_readdata = {13'h0000, o_valid, 1'b0, o_en, o_max_hi};
		`IFS_OP_CNT: next_readdata = {12'h000, o_count};
		`IFS_OP_PARENT: next_readdata = o_parent;
		`IFS_OP_DATA: next_readdata = {o_kind, o_retcyc};
		default: next_readdata = 32'h00000000;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			// drop waitrequest for one cycle after the request is seen
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= next_readdata;
			end
		end
	end

endmodule

`default_nettype wire

// [verification/ifs_sampler_props.sv]
// assertion checker for the sampler ports
`default_nettype none
// ==========
// checker
module ifs_sampler_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic fetch_tag_req,
	input wire logic fetch_tag_start,
	input wire logic tag_done,
	input wire logic tag_abort,
	input wire logic fetch_sample_irq,
	input wire logic op_retire,
	input wire logic op_flush,
	input wire logic op_sample_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic req;
	logic wr_end;
	assign req = avs_read || avs_write;
	assign wr_end = avs_write && !avs_waitrequest;
	chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop");
	chk_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low without request");
	chk_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("readdata moved");
	chk_tag_release: assert property (fetch_tag_start |=> !fetch_tag_req)
		else $error("tag request held after start");
	chk_pend_no_tag: assert property (fetch_sample_irq |-> !fetch_tag_req)
		else $error("armed with sample pending");
	chk_fetch_irq: assert property ((tag_done || tag_abort) |-> ##[1:4] fetch_sample_irq)
		else $error("no fetch interrupt");
	chk_irq_hold: assert property (fetch_sample_irq && !wr_end && !$past(wr_end)
		|=> fetch_sample_irq)
		else $error("fetch interrupt dropped");
	chk_op_irq: assert property (op_retire && !op_flush |-> ##[1:4] op_sample_irq)
		else $error("no op interrupt");
	chk_flush_drop: assert property (op_flush |=> (!op_sample_irq) [*3])
		else $error("flushed op reported");
	cover property (fetch_tag_req ##[1:3] fetch_tag_start);
	cover property (tag_abort);
	cover property (op_flush);
endmodule
bind ifs_sampler ifs_sampler_props ifs_sampler_props_i (.clk(clk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.avs_readdata(avs_readdata), .fetch_tag_req(fetch_tag_req),
	.fetch_tag_start(fetch_tag_start), .tag_done(tag_done), .tag_abort(tag_abort),
	.fetch_sample_irq(fetch_sample_irq), .op_retire(op_retire), .op_flush(op_flush),
	.op_sample_irq(op_sample_irq));
`default_nettype wire

// [verification/ifs_pipe_model.sv]
// fetch and op pipeline model driving the tag events
`default_nettype none
module ifs_pipe_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic abort_mode,
	input wire logic flush_mode,
	input wire logic fetch_tag_req,
	input wire logic op_tag_req,
	output logic fetch_tag_start,
	output logic tag_xlat_done,
	output logic tag_xlat_ok,
	output logic tag_l1_miss,
	output logic tag_l2_miss,
	output logic tag_ic_access,
	output logic tag_ic_miss,
	output logic tag_done,
	output logic tag_abort,
	output logic op_tagged,
	output logic op_retire,
	output logic op_flush
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ph;
	logic [2:0] oph;
	// ==========
	// phases
	always @(posedge clk) begin
		ph <= (rst || (ph == 3'h0 && !fetch_tag_req)) ? 3'h0 : ph + 3'h1;
		oph <= (rst || (oph == 3'h0 && !op_tag_req)) ? 3'h0 : oph + 3'h1;
	end
	// each access is retried once so only the first attempt misses
	assign fetch_tag_start = ph == 3'h1;
	assign tag_xlat_done = (ph == 3'h2 || ph == 3'h4) && !abort_mode;
	assign tag_xlat_ok = ph == 3'h4;
	assign tag_l1_miss = ph == 3'h2;
	assign tag_l2_miss = ph == 3'h2;
	assign tag_ic_access = (ph == 3'h3 || ph == 3'h5) && !abort_mode;
	assign tag_ic_miss = ph == 3'h3;
	assign tag_done = ph == 3'h6 && !abort_mode;
	assign tag_abort = ph == 3'h3 && abort_mode;
	assign op_tagged = oph == 3'h1;
	assign op_retire = oph == 3'h4 && !flush_mode;
	assign op_flush = oph == 3'h4 && flush_mode;
endmodule
`default_nettype wire

// [verification/ifs_sampler_tb.sv]
// testbench for the fetch and op sampler
`default_nettype none
`include "ifs_defs.vh"
module ifs_sampler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = '0, rst = '1, avs_read = '0, avs_write = '0, fetch_complete = '0;
	logic abort_mode = '0, flush_mode = '0;
	logic [5:0] avs_address = '0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = '0, avs_readdata, fetch_vaddr = 32'h12345670, rv;
	logic [31:0] tag_paddr = 32'h0abcd000, op_parent_addr = '0;
	logic [1:0] tag_page_size = '0;
	logic [15:0] op_kind_data = '0;
	logic avs_waitrequest, fetch_tag_req, fetch_tag_start, tag_xlat_done, tag_xlat_ok;
	logic tag_l1_miss, tag_l2_miss, tag_ic_access, tag_ic_miss, tag_done, tag_abort;
	logic fetch_sample_irq;
	logic op_tag_req, op_tagged, op_retire, op_flush, op_sample_irq;
	int mismatches = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	ifs_sampler ifs_sampler_i (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .fetch_complete(fetch_complete),
		.fetch_tag_req(fetch_tag_req), .fetch_tag_start(fetch_tag_start),
		.fetch_vaddr(fetch_vaddr), .tag_xlat_done(tag_xlat_done), .tag_xlat_ok(tag_xlat_ok),
		.tag_l1_miss(tag_l1_miss), .tag_l2_miss(tag_l2_miss), .tag_paddr(tag_paddr),
		.tag_page_size(tag_page_size), .tag_ic_access(tag_ic_access),
		.tag_ic_miss(tag_ic_miss), .tag_done(tag_done), .tag_abort(tag_abort),
		.fetch_sample_irq(fetch_sample_irq), .op_tag_req(op_tag_req), .op_tagged(op_tagged),
		.op_retire(op_retire), .op_flush(op_flush), .op_parent_addr(op_parent_addr),
		.op_kind_data(op_kind_data), .op_sample_irq(op_sample_irq));
	ifs_pipe_model ifs_pipe_model_i (.clk(clk), .rst(rst), .abort_mode(abort_mode),
		.flush_mode(flush_mode), .fetch_tag_req(fetch_tag_req), .op_tag_req(op_tag_req),
		.fetch_tag_start(fetch_tag_start), .tag_xlat_done(tag_xlat_done),
		.tag_xlat_ok(tag_xlat_ok), .tag_l1_miss(tag_l1_miss), .tag_l2_miss(tag_l2_miss),
		.tag_ic_access(tag_ic_access), .tag_ic_miss(tag_ic_miss), .tag_done(tag_done),
		.tag_abort(tag_abort), .op_tagged(op_tagged), .op_retire(op_retire),
		.op_flush(op_flush));
	// ==========
	// helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s exp %h saw %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			@(posedge clk);
			fetch_complete <= 1'b1;
		end
		@(posedge clk);
		fetch_complete <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_regs();
		bus(0, `IFS_FETCH_CTL, '0);
		chk("ctl reset", '0, rv);
		bus(0, 6'h3c, '0);
		chk("unmapped", '0, rv);
	endtask
	task automatic t_fetch_done();
		tag_page_size <= 2'h2;
		bus(1, `IFS_FETCH_CTL, 32'h1);
		bus(1, `IFS_FETCH_CTL, 32'h10001);
		pulses(15);
		bus(0, `IFS_FETCH_CNT, '0);
		chk("count", 32'hf, rv);
		chk("early tag", '0, {31'h0, fetch_tag_req});
		pulses(1);
		for (int i = 0; i < 5 && fetch_tag_req !== 1'b1; i++) @(posedge clk);
		chk("tag", 32'h1, {31'h0, fetch_tag_req});
		for (int i = 0; i < 30 && fetch_sample_irq !== 1'b1; i++) @(posedge clk);
		chk("irq", 32'h1, {31'h0, fetch_sample_irq});
		bus(0, `IFS_FETCH_INFO, '0);
		chk("flags", 32'h6f, {25'h0, rv[22:16]});
		chk("latency", 32'h1, {31'h0, rv[15:0] >= 16'h4 && rv[15:0] <= 16'h6});
		bus(0, `IFS_FETCH_VADDR, '0);
		chk("vaddr", fetch_vaddr, rv);
		bus(0, `IFS_FETCH_PADDR, '0);
		chk("paddr", tag_paddr, rv);
		bus(0, `IFS_FETCH_CNT, '0);
		chk("reload", '0, rv);
		bus(1, `IFS_FETCH_CTL, 32'h10001);
		repeat (3) @(posedge clk);
		chk("irq clear", '0, {31'h0, fetch_sample_irq});
	endtask
	task automatic t_fetch_abort();
		logic [31:0] held;
		abort_mode <= 1'b1;
		fetch_vaddr <= 32'h00fed000;
		bus(1, `IFS_FETCH_CTL, 32'h30001);
		pulses(16);
		for (int i = 0; i < 30 && fetch_sample_irq !== 1'b1; i++) @(posedge clk);
		chk("abort irq", 32'h1, {31'h0, fetch_sample_irq});
		bus(0, `IFS_FETCH_CTL, '0);
		chk("rand ctl", 32'h70001, rv);
		bus(0, `IFS_FETCH_INFO, '0);
		chk("abort flags", '0, {25'h0, rv[22:16]});
		chk("abort lat", 32'h1, {31'h0, rv[15:0] >= 16'h1 && rv[15:0] <= 16'h3});
		bus(0, `IFS_FETCH_VADDR, '0);
		chk("abort vaddr", 32'h00fed000, rv);
		bus(0, `IFS_FETCH_CNT, '0);
		chk("rand count", '0, rv & 32'hfffffff0);
		held = rv;
		bus(1, `IFS_FETCH_CTL, '0);
		pulses(20);
		bus(0, `IFS_FETCH_CNT, '0);
		chk("held count", held, rv);
	endtask
	task automatic t_op();
		op_parent_addr <= 32'h00004444;
		op_kind_data <= 16'h5a5a;
		bus(1, `IFS_OP_CTL, 32'h1);
		bus(1, `IFS_OP_CTL, 32'h10001);
		for (int i = 0; i < 60 && op_sample_irq !== 1'b1; i++) @(posedge clk);
		chk("op irq", 32'h1, {31'h0, op_sample_irq});
		bus(0, `IFS_OP_PARENT, '0);
		chk("parent", 32'h00004444, rv);
		bus(0, `IFS_OP_DATA, '0);
		chk("op kind", 32'h5a5a, {16'h0, rv[31:16]});
		chk("retire", 32'h1, {31'h0, rv[15:0] >= 16'h2 && rv[15:0] <= 16'h4});
		flush_mode <= 1'b1;
		bus(1, `IFS_OP_CTL, 32'h10001);
		repeat (40) @(posedge clk);
		chk("flush irq", '0, {31'h0, op_sample_irq});
		bus(1, `IFS_OP_CTL, '0);
	endtask
	initial begin
		#100us;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_fetch_done();
		t_fetch_abort();
		t_op();
		give_verdict();
	end
endmodule
`default_nettype wire
